//--- design/dio_ref_regs.sv
// register bank for digital pins, conversion start/busy and reference/oscillator setup
`timescale 1ns/10ps
`default_nettype none
module dio_ref_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire dio_ref_pkg::reg_req_t req,
    input wire logic [3:0] pinIn,
    input wire logic cclkIn,
    input wire logic [1:0] clockDivideSel,
    input wire logic oscEnablePin,
    output logic [7:0] rdata,
    output logic [3:0] pinOut,
    output logic [3:0] pinOe_n,
    output logic cclkOe_n,
    output logic convStart,
    output logic convBusy,
    output dio_ref_pkg::ana_ctl_t anaCtl
);
    import dio_ref_pkg::*;

    typedef enum logic [1:0] {
        CV_IDLE,
        CV_WAIT,
        CV_RUN
    } conv_state_t;

    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] dir;
        logic [5:0] refOsc;
        conv_state_t cst;
        logic [1:0] edgeCnt;
        logic [4:0] runCnt;
        logic [2:0] divCnt;
        logic cclkPrev;
        logic [7:0] rdata;
        logic [3:0] pinOut;
        logic [3:0] pinOe_n;
        logic cclkOe_n;
        logic convStart;
        logic convBusy;
        ana_ctl_t ana;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic cclkFall;
    logic divTick;

    // divider ratio is 1, 2, 4 or 8 falling edges of the conversion clock
    function automatic logic [2:0] divMask(input logic [1:0] sel);
        unique case (sel)
            2'h0: divMask = 3'h0;
            2'h1: divMask = 3'h1;
            2'h2: divMask = 3'h3;
            2'h3: divMask = 3'h7;
        endcase
    endfunction : divMask

    assign cclkFall = st_ff.cclkPrev && !cclkIn;
    assign divTick = cclkFall && ((st_ff.divCnt & divMask(clockDivideSel)) == divMask(clockDivideSel));

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cclkPrev = cclkIn;
        nxt_st.convStart = 1'b0;
        if (cclkFall) begin
            nxt_st.divCnt = 3'(st_ff.divCnt + 3'h1);
        end
        // register writes; reserved bits dropped so they always read zero
        if (req.wrStb) begin
            unique case (req.addr)
                ADDR_PIN_STATE: begin
                    // [RULE_01] [RULE_15] latch holds host value; input pins ignore it
                    nxt_st.latch = req.wdata[3:0];
                end
                ADDR_PIN_DIR: nxt_st.dir = req.wdata[3:0];
                // [RULE_06] host writes zeros to bits 7:6, ignored anyway
                ADDR_REF_OSC: nxt_st.refOsc = req.wdata[5:0];
                default: ;
            endcase
        end
        // conversion sequencer: start counted on raw falling edges, run on divided clock
        unique case (st_ff.cst)
            CV_IDLE: begin
                // [RULE_03] start request arms the edge counter
                if (req.wrStb && req.addr == ADDR_PIN_STATE && req.wdata[BIT_CONV_BUSY]) begin
                    nxt_st.cst = CV_WAIT;
                    nxt_st.edgeCnt = 2'h0;
                end
            end
            CV_WAIT: begin
                if (cclkFall) begin
                    nxt_st.edgeCnt = 2'(st_ff.edgeCnt + 2'h1);
                    // [RULE_03] second falling edge starts conversion
                    if (2'(st_ff.edgeCnt + 2'h1) == START_EDGES) begin
                        nxt_st.cst = CV_RUN;
                        nxt_st.runCnt = 5'h00;
                        nxt_st.convStart = 1'b1;
                    end
                end
            end
            CV_RUN: begin
                if (divTick) begin
                    nxt_st.runCnt = 5'(st_ff.runCnt + 5'h01);
                    if (5'(st_ff.runCnt + 5'h01) == CONV_CYCLES) begin
                        nxt_st.cst = CV_IDLE;
                    end
                end
            end
            default: nxt_st.cst = CV_IDLE;
        endcase
        // [RULE_04] busy level kept in a flop so the output is glitch free
        nxt_st.convBusy = nxt_st.cst == CV_RUN;
        // [RULE_05] [RULE_15] direction drives enables, active low
        nxt_st.pinOe_n = ~nxt_st.dir;
        nxt_st.pinOut = nxt_st.latch;
        // [RULE_08] oscillator drives conversion clock pin only when enabled
        nxt_st.cclkOe_n = !nxt_st.refOsc[BIT_INT_CLK_EN];
        // [RULE_09] oscillator runs on enable bit, select with ref power, or pin
        nxt_st.ana.oscRun = nxt_st.refOsc[BIT_INT_CLK_EN] || oscEnablePin
            || (nxt_st.refOsc[BIT_REF_CLK_SEL] && nxt_st.refOsc[BIT_VREF_ON]);
        // [RULE_07] reference clock source
        nxt_st.ana.refClkFromOsc = nxt_st.refOsc[BIT_REF_CLK_SEL];
        // [RULE_11] [RULE_12] power controls
        nxt_st.ana.vrefOn = nxt_st.refOsc[BIT_VREF_ON];
        nxt_st.ana.bufOn = nxt_st.refOsc[BIT_BUF_ON];
        // [RULE_13] [RULE_14] bandgap overrides two-volt select
        if (nxt_st.refOsc[BIT_BANDGAP]) begin
            nxt_st.ana.vrefLevel = VREF_1V15;
        end else if (nxt_st.refOsc[BIT_TWO_VOLT]) begin
            nxt_st.ana.vrefLevel = VREF_2V048;
        end else begin
            nxt_st.ana.vrefLevel = VREF_2V5;
        end
        // read data sampled on the read strobe, held until the next one
        if (req.rdStb) begin
            unique case (req.addr)
                // [RULE_02] [RULE_04] [RULE_16] pin levels and live busy, bits 6:4 zero
                ADDR_PIN_STATE: nxt_st.rdata = {st_ff.cst != CV_IDLE, 3'h0, pinIn};
                ADDR_PIN_DIR: nxt_st.rdata = {4'h0, st_ff.dir};
                ADDR_REF_OSC: nxt_st.rdata = {2'h0, st_ff.refOsc};
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            // [RULE_10] [RULE_17] all pins input, idle, clocks and reference off
            st_ff <= '0;
            st_ff.latch <= RST_PIN_LATCH;
            st_ff.dir <= RST_PIN_DIR;
            st_ff.refOsc <= RST_REF_OSC;
            st_ff.cst <= CV_IDLE;
            st_ff.pinOe_n <= 4'hF;
            st_ff.cclkOe_n <= 1'b1;
            st_ff.ana.vrefLevel <= VREF_2V5;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign pinOut = st_ff.pinOut;
    assign pinOe_n = st_ff.pinOe_n;
    assign cclkOe_n = st_ff.cclkOe_n;
    assign convStart = st_ff.convStart;
    assign convBusy = st_ff.convBusy;
    assign anaCtl = st_ff.ana;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_input_pin_ignored: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_01
        req.rdStb && req.addr == ADDR_PIN_STATE
        |=> ((rdata[3:0] ^ $past(pinIn)) & $past(pinOe_n)) == 4'h0)
        else $error("input pin read not from pin");
    a_read_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_16
        $past(req.rdStb) && $past(req.addr) == ADDR_PIN_STATE |-> rdata[6:4] == 3'h0)
        else $error("reserved pin state bits not zero");
    a_start_after_two: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
        convStart |-> $past(st_ff.cst) == CV_WAIT && $past(st_ff.edgeCnt) == 2'h1)
        else $error("conversion started on wrong edge");
    a_busy_read_live: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_04
        req.rdStb && req.addr == ADDR_PIN_STATE && st_ff.cst == CV_IDLE |=> !rdata[7])
        else $error("busy read while idle");
    a_dir_sets_oe: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_05
        req.wrStb && req.addr == ADDR_PIN_DIR |=> pinOe_n == ~$past(req.wdata[3:0]))
        else $error("direction write not applied");
    a_out_follows_latch: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_15
        req.wrStb && req.addr == ADDR_PIN_STATE |=> pinOut == $past(req.wdata[3:0]))
        else $error("output latch not driven");
    a_osc_pin_drive: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_08
        cclkOe_n == !st_ff.refOsc[BIT_INT_CLK_EN] && (cclkOe_n || anaCtl.oscRun))
        else $error("oscillator pin drive mismatch");
    a_osc_auto_on: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_09
        oscEnablePin |=> anaCtl.oscRun)
        else $error("oscillator not on with enable pin");
    a_bandgap_wins: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_13
        st_ff.refOsc[BIT_BANDGAP] |-> anaCtl.vrefLevel == VREF_1V15)
        else $error("bandgap not selected");
    a_reset_defaults: assert property (@(posedge clk_sys) // RULE_17
        $past(!rstn) |-> pinOe_n == 4'hF && !convBusy && anaCtl.vrefLevel == VREF_2V5)
        else $error("reset defaults wrong");
    a_busy_read_set: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_04
        req.rdStb && req.addr == ADDR_PIN_STATE && st_ff.cst != CV_IDLE |=> rdata[7])
        else $error("busy not read while converting");
    a_busy_from_start: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_04
        convStart |-> convBusy)
        else $error("busy low on conversion start");
    a_dir_read_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_16
        req.rdStb && req.addr == ADDR_PIN_DIR |=> rdata[7:4] == 4'h0)
        else $error("direction reserved bits not zero");
endmodule : dio_ref_regs
`default_nettype wire

//--- design/dio_ref_pkg.sv
// shared constants and carrier types for the digital pin and reference configuration registers
//
// Contract
// [RULE_01] A pin set as input ignores host writes to its state bit; the bit follows the pin level only.
// [RULE_02] Reads of address 5 return the actual pin levels, not the internal output latch.
// [RULE_03] Writing conversion_start_busy as 1 starts a conversion on the second falling conversion clock edge after the write.
// [RULE_04] A read returns conversion_start_busy as 1 while a conversion is in progress, else 0.
// [RULE_05] A pin_output_enable bit at 1 makes its pin an output, at 0 an input.
// [RULE_06] The host writes zeros to reserved bits 7 and 6 of the reference/oscillator register.
// [RULE_07] reference_clock_select at 1 clocks the reference from the internal oscillator, at 0 from the divided conversion clock.
// [RULE_08] internal_clock_enable at 1 runs the oscillator and drives it out on the conversion clock pin; at 0 the pin is an input.
// [RULE_09] The oscillator also runs when reference_clock_select and vref_power_on are both 1 or the enable pin is high.
// [RULE_10] Reset clears internal_clock_enable and reference_clock_select.
// [RULE_11] vref_power_on powers the reference up at 1 and down at 0, reset value 0.
// [RULE_12] buffer_power_on powers the reference buffer up at 1 and down at 0, reset value 0.
// [RULE_13] bandgap_select at 1 selects the 1.15V reference and ignores two_volt_select.
// [RULE_14] With bandgap_select at 0, two_volt_select picks 2.5V at 0 and 2.048V at 1; both reset to 0.
// [RULE_15] A pin set as output is driven with the value last written into its state bit.
// [RULE_16] Bits 6 to 4 of address 5 and all reserved bits read as zero.
// [RULE_17] Reset makes every pin an input and clears conversion_start_busy.
package dio_ref_pkg;
    localparam logic [4:0] ADDR_PIN_STATE = 5'h05;
    localparam logic [4:0] ADDR_PIN_DIR = 5'h06;
    localparam logic [4:0] ADDR_REF_OSC = 5'h07;
    localparam int BIT_CONV_BUSY = 7;
    localparam int BIT_REF_CLK_SEL = 5;
    localparam int BIT_INT_CLK_EN = 4;
    localparam int BIT_VREF_ON = 3;
    localparam int BIT_BUF_ON = 2;
    localparam int BIT_TWO_VOLT = 1;
    localparam int BIT_BANDGAP = 0;
    localparam logic [3:0] RST_PIN_LATCH = 4'h0;
    localparam logic [3:0] RST_PIN_DIR = 4'h0;
    localparam logic [5:0] RST_REF_OSC = 6'h00;
    // conversion length in divided conversion clock periods (arbitrary plain default)
    localparam logic [4:0] CONV_CYCLES = 5'h10;
    // falling conversion clock edges from write to start
    localparam logic [1:0] START_EDGES = 2'h2;

    typedef enum logic [1:0] {
        VREF_2V5,
        VREF_2V048,
        VREF_1V15
    } vref_level_t;

    // register write/read request from the serial interface
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // analog control outputs
    typedef struct packed {
        logic oscRun;
        logic refClkFromOsc;
        logic vrefOn;
        logic bufOn;
        vref_level_t vrefLevel;
    } ana_ctl_t;
endpackage : dio_ref_pkg

//--- tb/host_model.sv
// host model issuing single byte register requests
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output var dio_ref_pkg::reg_req_t req,
    input wire logic [7:0] rdata
);
    import dio_ref_pkg::*;
    initial req = '0;
    // one write strobe; released fields go inverted so stale values never pass
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_REF_OSC) v[7:6] = 2'h0;
        @(posedge clk_sys) #1;
        req = '{1'b1, 1'b0, a, v};
        @(posedge clk_sys) #1;
        req = '{1'b0, 1'b0, ~a, ~v};
    endtask : wr
    // read strobe; data is taken right after the edge that sampled it
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1;
        req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys) #1;
        d = rdata;
        req = '{1'b0, 1'b0, ~a, 8'hFF};
    endtask : rd
endmodule : host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the pin and reference register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dio_ref_pkg::*;
    typedef struct packed {logic [7:0] d; logic [5:0] ana; logic oe;} row_t;
    logic clk_sys, rstn, cclkIn, oscEnablePin, cclkOe_n, convStart, convBusy;
    logic [3:0] pinIn, pinOut, pinOe_n;
    logic [1:0] clockDivideSel;
    logic [7:0] rdata, r;
    reg_req_t req;
    ana_ctl_t anaCtl;
    int fail_count = 0;
    int cmp_count = 0;
    int starts = 0;
    int falls = 0;
    // config byte, expected analog controls, expected clock pin enable
    row_t rows [9] = '{'{8'h00, 6'h00, 1'b1}, '{8'h02, 6'h01, 1'b1}, '{8'h03, 6'h02, 1'b1},
        '{8'h01, 6'h02, 1'b1}, '{8'h08, 6'h08, 1'b1}, '{8'h04, 6'h04, 1'b1},
        '{8'h10, 6'h20, 1'b0}, '{8'h20, 6'h10, 1'b1}, '{8'h28, 6'h38, 1'b1}};

    dio_ref_regs i_dut (.clk_sys(clk_sys), .rstn(rstn), .req(req), .pinIn(pinIn), .cclkIn(cclkIn),
        .clockDivideSel(clockDivideSel), .oscEnablePin(oscEnablePin), .rdata(rdata), .pinOut(pinOut),
        .pinOe_n(pinOe_n), .cclkOe_n(cclkOe_n), .convStart(convStart), .convBusy(convBusy),
        .anaCtl(anaCtl));
    host_model i_host (.clk_sys(clk_sys), .req(req), .rdata(rdata));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // start pulses counted mid-cycle, clear of the edge that launches them
    always @(negedge clk_sys) if (convStart === 1'b1) starts++;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ----------------
    // main sequence
    // ----------------
    initial begin
        rstn = 1'b0;
        pinIn = 4'h0;
        cclkIn = 1'b1;
        clockDivideSel = 2'h0;
        oscEnablePin = 1'b0;
        cyc(12);
        rstn = 1'b1;
        chk({4'h0, pinOe_n}, 8'h0F);
        chk({1'b0, cclkOe_n, anaCtl}, 8'h40);
        i_host.rd(ADDR_REF_OSC, r);
        chk(r, 8'h00);
        i_host.rd(ADDR_PIN_STATE, r);
        chk(r, 8'h00);
        $display("test reset done");
        // table rows: all zero, each reference and oscillator bit alone, and the combinations 03 and 28
        foreach (rows[i]) begin
            i_host.wr(ADDR_REF_OSC, rows[i].d);
            chk({1'b0, cclkOe_n, anaCtl}, {1'b0, rows[i].oe, rows[i].ana});
            i_host.rd(ADDR_REF_OSC, r);
            chk(r, rows[i].d);
        end
        $display("test table done");
        // pins: latch differs from level, upper direction bits dropped
        i_host.wr(ADDR_PIN_DIR, 8'hF5);
        chk({4'h0, pinOe_n}, 8'h0A);
        i_host.rd(ADDR_PIN_DIR, r);
        chk(r, 8'h05);
        i_host.wr(ADDR_PIN_STATE, 8'h76);
        chk({4'h0, pinOut & ~pinOe_n}, 8'h04);
        pinIn = 4'h9;
        i_host.rd(ADDR_PIN_STATE, r);
        chk(r, 8'h09);
        i_host.wr(5'h08, 8'hFF);
        i_host.rd(5'h08, r);
        chk(r, 8'h00);
        i_host.wr(ADDR_REF_OSC, 8'h00);
        oscEnablePin = 1'b1;
        cyc(2);
        chk({7'h0, anaCtl.oscRun}, 8'h01);
        oscEnablePin = 1'b0;
        $display("test pins done");
        // conversion starts only on the second falling clock edge
        i_host.wr(ADDR_PIN_STATE, 8'h80);
        cclkIn = 1'b0;
        cyc(3);
        cclkIn = 1'b1;
        cyc(3);
        chk(8'(starts), 8'h00);
        cclkIn = 1'b0;
        cyc(3);
        chk(8'(starts), 8'h01);
        i_host.rd(ADDR_PIN_STATE, r);
        chk(r, 8'h89);
        chk({7'h0, convBusy}, 8'h01);
        for (falls = 0; falls < 40 && convBusy !== 1'b0; falls++) begin
            cclkIn = 1'b1;
            cyc(2);
            cclkIn = 1'b0;
            cyc(2);
        end
        chk(8'(falls), 8'(CONV_CYCLES));
        i_host.rd(ADDR_PIN_STATE, r);
        chk(r, 8'h09);
        // divide by two: two falls per tick; a start write while running is refused
        clockDivideSel = 2'h1;
        cclkIn = 1'b1;
        i_host.wr(ADDR_PIN_STATE, 8'h80);
        for (falls = 0; falls < 80 && (falls < 2 || convBusy !== 1'b0); falls++) begin
            cclkIn = 1'b0;
            cyc(2);
            cclkIn = 1'b1;
            cyc(2);
            if (falls == 4) begin
                i_host.wr(ADDR_PIN_STATE, 8'h80);
            end
        end
        chk(8'(falls), 8'(2 + 2 * CONV_CYCLES));
        chk(8'(starts), 8'h02);
        $display("test conversion done");
        // reset with every reference bit set brings every default back
        i_host.wr(ADDR_REF_OSC, 8'h3F);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        chk({4'h0, pinOe_n}, 8'h0F);
        chk({1'b0, cclkOe_n, anaCtl}, 8'h40);
        i_host.rd(ADDR_REF_OSC, r);
        chk(r, 8'h00);
        $display("test second reset done");
        test_done();
    end

    // watchdog well past the expected few hundred cycles
    initial begin
        #(3000 * 100);
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
